// [src/ssp_pkg.sv]
// Purpose: shared constants and types of the SPI slave port
// Assumes: AXI4-Lite access, one aligned word per register
// Notes: byte address of a register is four times its index
//
// Overview of operation
// - Select high returns transfer state and bit counter to idle.
// - Select rising mid-byte stops shifting; partial data is dropped.
// - Unbuffered and deselected, SCK is ignored but data writes land.
// - Master selects by pulling select low; shifting starts at next SCK.
// - Unbuffered mode sets the done flag after a whole byte.
// - Unbuffered write during a transfer is dropped, collision flag set.
// - Buffer enable adds a transmit buffer; wait bit picks sub-mode.
// - Buffered, wait clear: writes fill buffer; first byte is a dummy.
// - Write into full buffer while empty flag is low is lost.
// - Empty flag clears on buffer write, sets when buffer enters shifter.
// - Buffered receive flag sets one cycle after empty flag rises.
// - Transfer flag sets one cycle later, only when nothing is left.
// - Wait set: first write while deselected loads shifter next cycle.
// - Four polarity and phase modes; launch and capture on opposite edges.
// - Control bit 6 picks order: 0 MSB first, 1 LSB first.
// - One interrupt output fed by select, empty, transfer, receive flags.
// - Interrupt asserted while any enabled flag stays set.
// - Runs in idle sleep; deeper sleep aborts any transfer.
// - Modes 0,1 idle low, 2,3 idle high; even modes sample leading edge.
// - Unbuffered done flag clears on interrupt taken or flag-read-then-data.
// - Buffered receive flag follows unread data; writing one clears it.

package ssp_pkg;

    // ****************************************
    // Register indices and reset values
    // ****************************************
    localparam logic [2:0] IDX_CTL_PRI = 3'h0;
    localparam logic [2:0] IDX_CTL_SEC = 3'h1;
    localparam logic [2:0] IDX_IRQ_EN = 3'h2;
    localparam logic [2:0] IDX_IRQ_FLG = 3'h3;
    localparam logic [2:0] IDX_DATA = 3'h4;
    localparam logic [7:0] RST_CTL_PRI = 8'h00;
    localparam logic [7:0] RST_CTL_SEC = 8'h00;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;
    localparam logic [7:0] RST_IRQ_FLG = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;

    // Implemented bits; the rest read zero
    localparam logic [7:0] MSK_CTL_PRI = 8'h77;
    localparam logic [7:0] MSK_CTL_SEC = 8'hc7;
    localparam logic [7:0] MSK_IRQ_EN = 8'hf1;
    localparam logic [7:0] MSK_IRQ_FLG = 8'hf1;
    localparam logic [7:0] MSK_IRQ_BUF = 8'hf0;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int B_ENABLE = 0;
    localparam int B_ORDER = 6;
    localparam int B_BUF_MODE = 7;
    localparam int B_BUF_WAIT = 6;
    localparam int B_PHASE = 0;
    localparam int B_POLAR = 1;
    localparam int B_IRQ_PLAIN = 0;
    localparam int B_RCV_DONE = 7;
    localparam int B_XFER_DONE = 6;
    localparam int B_BUF_FREE = 5;
    localparam int B_SEL_TRIG = 4;
    localparam int B_OVERFLOW = 0;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] RX_FULL = 2'h2;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic sck;
        logic mosi;
        logic sel_n;
    } ssp_pin_t;
    localparam ssp_pin_t PIN_RST = '{sck: 1'b0, mosi: 1'b0, sel_n: 1'b1};

    typedef enum logic {ST_IDLE, ST_SHIFT} ssp_st_t;

endpackage

// [src/ssp_top.sv]
// Purpose: slave side of an 8-bit SPI port with AXI4-Lite registers
// Assumes: clk 20 MHz; SCK high and low each last over three clk
// Notes: master, prescaler and select-disable bits are stored only
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module ssp_top
    import ssp_pkg::*;
#(
    parameter int AW = 5
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sck_pin,
    input wire logic mosi_pin,
    input wire logic sel_n_pin,
    output logic miso_o,
    output logic miso_oe,
    input wire logic sleep_deep,
    input wire logic irq_ack,
    output logic irq
);

    if (AW < 5)
    begin : g_bad_aw
        $error("ssp_top: AW must be at least 5");
    end

    // ****************************************
    // Declarations
    // ****************************************
    ssp_pin_t s1_q, s2_q, s3_q, pin_q, pin_d;
    logic [2:0] agree;
    logic sck_old_q, sel_old_q;
    logic awr_q, awh_q, wr_q, wh_q, bv_q, arr_q, rv_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [AW-3:0] widx_q, ridx;
    logic [7:0] wd_q;
    logic wb0_q;
    logic aw_take, w_take, wr_go, ar_take, w_bad, r_bad;
    logic wpa, wsb, wen, wfl, wdt, rd_flg, rd_dat;
    logic [7:0] cta_q, ctb_q, ien_q, flg_q, flg_d, fs, fc;
    logic [7:0] rd_byte, ien_eff;
    logic en, buffer_mode_enable, buffer_wait_receive, lsbf, cpol, cpha;
    logic sck_chg, lead, trail, smp, lnch, sel, sel_fall, desel;
    ssp_st_t st_q;
    logic busy, done, obit;
    logic [2:0] cnt_q;
    logic [7:0] sh_q, sh_in, txb_q, rx0_q, rx1_q;
    logic txf_q, first_q, ld_dir, tx_wr, wcol;
    logic [1:0] rxn_q;
    logic pop, rx_empty, plain_clr, seen_q;
    logic d1_q, d2_q, txe_q, irq_src;
    logic miso_q, moe_q, irq_q;

    // ****************************************
    // Pin synchroniser
    // ****************************************
    // A bit is taken once the second and third stages agree
    assign agree = ~(s2_q ^ s3_q);
    assign pin_d = ssp_pin_t'((pin_q & ~agree) | (s3_q & agree));

    // Three stages, then filtered value and edge history
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= PIN_RST;
            s2_q <= PIN_RST;
            s3_q <= PIN_RST;
            pin_q <= PIN_RST;
            sck_old_q <= 1'b0;
            sel_old_q <= 1'b1;
        end
        else
        begin
            s1_q <= '{sck: sck_pin, mosi: mosi_pin, sel_n: sel_n_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= pin_d;
            sck_old_q <= pin_q.sck;
            sel_old_q <= pin_q.sel_n;
        end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    // Address and data are taken in either order; response follows both
    assign aw_take = s_axi_awvalid & awr_q;
    assign w_take = s_axi_wvalid & wr_q;
    assign wr_go = awh_q & wh_q & ~bv_q;
    assign ar_take = s_axi_arvalid & arr_q;
    assign ridx = s_axi_araddr[AW-1:2];
    assign w_bad = widx_q > (AW-2)'(IDX_DATA);
    assign r_bad = ridx > (AW-2)'(IDX_DATA);

    // Write side handshake
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awh_q <= 1'b0;
            wh_q <= 1'b0;
            awr_q <= 1'b1;
            wr_q <= 1'b1;
            bv_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            widx_q <= '0;
            wd_q <= 8'h00;
            wb0_q <= 1'b0;
        end
        else
        begin
            awh_q <= aw_take | (awh_q & ~wr_go);
            awr_q <= ~(aw_take | (awh_q & ~wr_go));
            wh_q <= w_take | (wh_q & ~wr_go);
            wr_q <= ~(w_take | (wh_q & ~wr_go));
            if (aw_take)
                widx_q <= s_axi_awaddr[AW-1:2];
            if (w_take)
            begin
                wd_q <= s_axi_wdata[7:0];
                wb0_q <= s_axi_wstrb[0];
            end
            if (wr_go)
            begin
                bv_q <= 1'b1;
                bresp_q <= w_bad ? RESP_SLVERR : RESP_OKAY;
            end
            else if (bv_q & s_axi_bready)
                bv_q <= 1'b0;
        end
    end

    // Read side; data captured at the address hand-shake
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arr_q <= 1'b1;
            rv_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            arr_q <= 1'b0;
            rv_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_byte};
            rresp_q <= r_bad ? RESP_SLVERR : RESP_OKAY;
        end
        else if (rv_q & s_axi_rready)
        begin
            arr_q <= 1'b1;
            rv_q <= 1'b0;
        end
    end

    // Register strobes; byte lane 0 carries every register
    assign wpa = wr_go & wb0_q & (widx_q == (AW-2)'(IDX_CTL_PRI));
    assign wsb = wr_go & wb0_q & (widx_q == (AW-2)'(IDX_CTL_SEC));
    assign wen = wr_go & wb0_q & (widx_q == (AW-2)'(IDX_IRQ_EN));
    assign wfl = wr_go & wb0_q & (widx_q == (AW-2)'(IDX_IRQ_FLG));
    assign wdt = wr_go & wb0_q & (widx_q == (AW-2)'(IDX_DATA));
    assign rd_flg = ar_take & (ridx == (AW-2)'(IDX_IRQ_FLG));
    assign rd_dat = ar_take & (ridx == (AW-2)'(IDX_DATA));

    // Read selection; holes answer zero with an error
    assign rd_byte = (ridx == (AW-2)'(IDX_CTL_PRI)) ? cta_q :
                     (ridx == (AW-2)'(IDX_CTL_SEC)) ? ctb_q :
                     (ridx == (AW-2)'(IDX_IRQ_EN)) ? ien_q :
                     (ridx == (AW-2)'(IDX_IRQ_FLG)) ? flg_q :
                     (ridx == (AW-2)'(IDX_DATA)) ? rx0_q : 8'h00;

    // Control registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cta_q <= RST_CTL_PRI;
            ctb_q <= RST_CTL_SEC;
            ien_q <= RST_IRQ_EN;
        end
        else
        begin
            if (wpa)
                cta_q <= wd_q & MSK_CTL_PRI;
            if (wsb)
                ctb_q <= wd_q & MSK_CTL_SEC;
            if (wen)
                ien_q <= wd_q & MSK_IRQ_EN;
        end
    end

    // ****************************************
    // Serial engine
    // ****************************************
    assign en = cta_q[B_ENABLE];
    assign lsbf = cta_q[B_ORDER];
    assign buffer_mode_enable = ctb_q[B_BUF_MODE];
    assign buffer_wait_receive = ctb_q[B_BUF_WAIT];
    assign cpol = ctb_q[B_POLAR];
    assign cpha = ctb_q[B_PHASE];

    // Leading edge leaves the idle level; phase picks the sample edge
    assign sck_chg = pin_q.sck ^ sck_old_q;
    assign lead = sck_chg & (pin_q.sck ^ cpol);
    assign trail = sck_chg & ~(pin_q.sck ^ cpol);
    assign smp = cpha ? trail : lead;
    assign lnch = cpha ? lead : trail;

    // Deep sleep deselects, so a running byte is abandoned
    assign sel = en & ~pin_q.sel_n & ~sleep_deep;
    assign sel_fall = en & sel_old_q & ~pin_q.sel_n;
    assign desel = ~sel_old_q & pin_q.sel_n;
    assign busy = (st_q == ST_SHIFT);
    assign done = sel & smp & (cnt_q == LAST_BIT);
    assign sh_in = lsbf ? {pin_q.mosi, sh_q[7:1]} : {sh_q[6:0], pin_q.mosi};
    assign obit = lsbf ? sh_q[0] : sh_q[7];

    // Data writes: direct load, buffer, collision or loss
    assign ld_dir = wdt & (buffer_mode_enable ? (buffer_wait_receive & en & pin_q.sel_n & first_q) : ~busy);
    assign wcol = wdt & ~buffer_mode_enable & busy;
    assign tx_wr = wdt & buffer_mode_enable & ~ld_dir & ~txf_q;

    // Transfer state and bit counter
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= ST_IDLE;
            cnt_q <= 3'h0;
        end
        else if (!sel)
        begin
            st_q <= ST_IDLE;
            cnt_q <= 3'h0;
        end
        else if (smp)
        begin
            st_q <= done ? ST_IDLE : ST_SHIFT;
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // Shifter; at byte end the buffer, if full, takes over
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sh_q <= RST_DATA;
        else if (ld_dir)
            sh_q <= wd_q;
        else if (done)
            sh_q <= (buffer_mode_enable & txf_q) ? txb_q : sh_in;
        else if (sel & smp)
            sh_q <= sh_in;
    end

    // Transmit buffer, only used in buffered mode
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txb_q <= RST_DATA;
            txf_q <= 1'b0;
            first_q <= 1'b1;
        end
        else
        begin
            if (tx_wr)
                txb_q <= wd_q;
            if (tx_wr)
                txf_q <= 1'b1;
            else if (done & buffer_mode_enable)
                txf_q <= 1'b0;
            if (desel)
                first_q <= 1'b1;
            else if (ld_dir & buffer_mode_enable)
                first_q <= 1'b0;
        end
    end

    // ****************************************
    // Receive buffer
    // ****************************************
    // Two entries when buffered, one overwritten entry otherwise
    assign pop = rd_dat & (rxn_q != 2'h0);
    assign rx_empty = pop & (rxn_q == 2'h1) & ~done;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx0_q <= RST_DATA;
            rx1_q <= RST_DATA;
            rxn_q <= 2'h0;
        end
        else if (done & ~buffer_mode_enable)
        begin
            rx0_q <= sh_in;
            rxn_q <= 2'h1;
        end
        else if (done & pop)
        begin
            rx0_q <= (rxn_q == RX_FULL) ? rx1_q : sh_in;
            rx1_q <= sh_in;
        end
        else if (done & (rxn_q == 2'h0))
        begin
            rx0_q <= sh_in;
            rxn_q <= 2'h1;
        end
        else if (done & (rxn_q == 2'h1))
        begin
            rx1_q <= sh_in;
            rxn_q <= RX_FULL;
        end
        else if (pop)
        begin
            rx0_q <= rx1_q;
            rxn_q <= rxn_q - 2'h1;
        end
    end

    // ****************************************
    // Flags and interrupt
    // ****************************************
    assign plain_clr = irq_ack | (seen_q & (rd_dat | wdt));

    // Set terms win over every clear in the same cycle
    always_comb
    begin
        fs = 8'h00;
        fc = wfl ? wd_q : 8'h00;
        fs[B_RCV_DONE] = buffer_mode_enable ? d1_q : done;
        fs[B_XFER_DONE] = buffer_mode_enable ? (d2_q & txe_q) : wcol;
        fs[B_BUF_FREE] = buffer_mode_enable & done & txf_q;
        fs[B_SEL_TRIG] = buffer_mode_enable & sel_fall;
        fs[B_OVERFLOW] = buffer_mode_enable & done & ~pop & (rxn_q == RX_FULL);
        fc[B_RCV_DONE] = fc[B_RCV_DONE] | (buffer_mode_enable ? rx_empty : plain_clr);
        fc[B_XFER_DONE] = fc[B_XFER_DONE] | (~buffer_mode_enable & plain_clr);
        fc[B_BUF_FREE] = fc[B_BUF_FREE] | tx_wr;
    end
    assign flg_d = ((flg_q & ~fc) | fs) & MSK_IRQ_FLG;

    // Unbuffered mode has one enable, steering the done flag
    assign ien_eff = buffer_mode_enable ? (ien_q & MSK_IRQ_BUF) : (8'(ien_q[B_IRQ_PLAIN]) << B_RCV_DONE);
    assign irq_src = |(flg_q & ien_eff);

    // Flags, completion pipeline and pins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flg_q <= RST_IRQ_FLG;
            seen_q <= 1'b0;
            d1_q <= 1'b0;
            d2_q <= 1'b0;
            txe_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            flg_q <= flg_d;
            seen_q <= rd_flg ? (flg_q[B_RCV_DONE] | flg_q[B_XFER_DONE]) : (seen_q & ~(rd_dat | wdt));
            d1_q <= done & buffer_mode_enable;
            d2_q <= d1_q;
            if (done)
                txe_q <= ~txf_q;
            irq_q <= irq_src;
        end
    end

    // Cpha 0 presents the bit before the first leading edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            miso_q <= 1'b0;
            moe_q <= 1'b0;
        end
        else
        begin
            if (!sel | lnch | (~cpha & ~busy))
                miso_q <= obit;
            moe_q <= sel;
        end
    end

    assign s_axi_awready = awr_q;
    assign s_axi_wready = wr_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arr_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign miso_o = miso_q;
    assign miso_oe = moe_q;
    assign irq = irq_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_desel_idle:
        assert property (!sel |=> (cnt_q == 3'h0) && (st_q == ST_IDLE))
        else $error("counter not cleared on deselect");
    chk_midbyte_abort:
        assert property (busy && !sel |=> !busy && !miso_oe && !d1_q)
        else $error("byte not abandoned on deselect");
    chk_sleep_abort:
        assert property (sleep_deep |=> !miso_oe && (cnt_q == 3'h0))
        else $error("deep sleep did not stop transfer");
    chk_plain_done:
        assert property (!buffer_mode_enable && done |=> flg_q[B_RCV_DONE])
        else $error("done flag missing");
    chk_write_coll:
        assert property (wdt && !buffer_mode_enable && busy |=> flg_q[B_XFER_DONE])
        else $error("collision flag missing");
    chk_full_lost:
        assert property (wdt && buffer_mode_enable && txf_q && !ld_dir |=> txb_q == $past(txb_q))
        else $error("full buffer overwritten");
    chk_buf_copy:
        assert property (done && buffer_mode_enable && txf_q |=> flg_q[B_BUF_FREE] && sh_q == $past(txb_q))
        else $error("buffer not moved to shifter");
    chk_rx_after_free:
        assert property (buffer_mode_enable && $rose(flg_q[B_BUF_FREE]) |=> flg_q[B_RCV_DONE])
        else $error("receive flag late");
    chk_xfer_after_rx:
        assert property (buffer_mode_enable && $rose(flg_q[B_XFER_DONE]) |-> $past(d1_q, 2) && $past(txe_q))
        else $error("transfer flag without completion");
    chk_direct_load:
        assert property (ld_dir && buffer_mode_enable |=> sh_q == $past(wd_q))
        else $error("direct load missed");
    chk_msb_first:
        assert property (done && !buffer_mode_enable && !lsbf |=> rx0_q == {$past(sh_q[6:0]), $past(pin_q.mosi)})
        else $error("received byte order wrong");
    chk_irq_follow:
        assert property (1'b1 |=> irq == $past(irq_src))
        else $error("interrupt does not follow flags");

    cov_plain_byte: cover property (done && !buffer_mode_enable);
    cov_buf_copy: cover property (done && buffer_mode_enable && txf_q);
    cov_overflow: cover property ($rose(flg_q[B_OVERFLOW]));
    cov_collision: cover property (wcol);

endmodule // ssp_top

`default_nettype wire

// [verification/ssp_mst_model.sv]
// Purpose: SPI master model driving the slave port pins
// Assumes: SCK period 400 ns, idle level taken from the mode field
// Notes: MOSI shows the inverse of its last bit once released
`timescale 1ns/1ps
`default_nettype none

module ssp_mst_model
(
    output logic sck,
    output logic mosi,
    output logic sel_n,
    input wire logic miso,
    input wire logic [1:0] mode,
    input wire logic lsb
);
    // ****************************************
    // Byte transfer; nb below 8 cuts the byte short
    // ****************************************
    initial
    begin
        sck = 1'h0;
        mosi = 1'h0;
        sel_n = 1'h1;
    end

    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        logic b;
        // Off the bench clock edges; SCK settles at idle before select falls
        #10 sck = mode[1];
        #200 sel_n = 1'h0;
        #400;
        // The slave answers some clocks after each edge, so MISO is read
        // at the end of its bit window, just before the next launch edge
        for (int i = 0; i < nb; i++)
        begin
            b = lsb ? tx[i] : tx[7-i];
            if (!mode[0])
                mosi = b;
            #200;
            if (mode[0] && i > 0)
                rx = lsb ? {miso, rx[7:1]} : {rx[6:0], miso};
            sck = ~mode[1];
            if (mode[0])
                mosi = b;
            #200;
            if (!mode[0])
                rx = lsb ? {miso, rx[7:1]} : {rx[6:0], miso};
            sck = mode[1];
        end
        // Last bit of the late phase, then deselect; SCK stays at idle
        #200;
        if (mode[0])
            rx = lsb ? {miso, rx[7:1]} : {rx[6:0], miso};
        #200 sel_n = 1'h1;
        mosi = ~mosi;
    endtask
endmodule // ssp_mst_model
`default_nettype wire

// [verification/spi_slave_buffered_port_test.sv]
// Purpose: self-checking bench of the SPI slave port
// Assumes: AXI4-Lite master tasks, master model on the pins
// Notes: expected bytes are kept in a queue beside the design
`timescale 1ns/1ps
`default_nettype none

module spi_slave_buffered_port_test import ssp_pkg::*;;
    localparam logic [7:0] FM = 8'hef; // Select trigger bit not judged
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [4:0] awaddr = 5'h0, araddr = 5'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic sleep_deep = 1'h0, irq_ack = 1'h0, lsb = 1'h0;
    logic [1:0] mode = 2'h0;
    logic awready, wready, bvalid, arready, rvalid, miso_o, miso_oe, irq, sck, mosi, sel_n;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] got, tx, mo;
    logic [7:0] rxq[$];
    int n_mismatch = 0, tests_run = 0, cyc = 0, m, k;
    // Released MISO carries no stale value
    wire logic miso_w = miso_oe ? miso_o : ~miso_o;

    always #25 clk = ~clk;

    ssp_top #(.AW(5)) uut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sck_pin(sck), .mosi_pin(mosi), .sel_n_pin(sel_n),
        .miso_o(miso_o), .miso_oe(miso_oe), .sleep_deep(sleep_deep),
        .irq_ack(irq_ack), .irq(irq));

    ssp_mst_model mst (.sck(sck), .mosi(mosi), .sel_n(sel_n), .miso(miso_w),
        .mode(mode), .lsb(lsb));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [2:0] i, input logic [7:0] d);
        @(posedge clk);
        awaddr <= {i, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end
        while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk({6'h0, bresp}, i > 4 ? {6'h0, RESP_SLVERR} : 8'h00);
    endtask

    task automatic rc(input logic [2:0] i, input logic [7:0] e, input logic [7:0] k = 8'hff);
        @(posedge clk);
        araddr <= {i, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
        end
        while (rvalid !== 1'h1);
        rready <= 1'h0;
        chk(rdata[7:0] & k, e);
        chk({6'h0, rresp}, i > 4 ? {6'h0, RESP_SLVERR} : 8'h00);
    endtask

    // Unbuffered byte: load, shift, check flag, irq and received data
    task automatic ub_byte(input logic [7:0] t, input logic [7:0] o);
        wr(IDX_DATA, t);
        mst.xfer(o, 8, got);
        chk(got, t);
        repeat (8) @(posedge clk);
        chk({7'h0, irq}, 8'h01);
        rc(IDX_IRQ_FLG, 8'h80, FM);
        rc(IDX_DATA, o);
        rc(IDX_IRQ_FLG, 8'h00, FM);
        chk({7'h0, irq}, 8'h00);
    endtask

    // Buffered byte: the model queue records what software will read
    task automatic bx(input logic [7:0] o, input logic [7:0] e);
        mst.xfer(o, 8, got);
        chk(got, e);
        rxq.push_back(o);
        repeat (8) @(posedge clk);
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog against a hung handshake
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 10000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        void'($urandom(33405));
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        for (m = 0; m < 6; m++)
            rc(m[2:0], 8'h00);
        wr(3'h6, 8'hff);
        tx = 8'($urandom);
        wr(IDX_CTL_PRI, tx);
        rc(IDX_CTL_PRI, tx & MSK_CTL_PRI);
        tx = 8'($urandom);
        wr(IDX_CTL_SEC, tx);
        rc(IDX_CTL_SEC, tx & MSK_CTL_SEC);
        // Every mode with both bit orders
        wr(IDX_IRQ_EN, 8'h01);
        for (m = 0; m < 8; m++)
        begin
            mode <= m[1:0];
            lsb <= m[2];
            wr(IDX_CTL_SEC, {6'h0, m[1:0]});
            wr(IDX_CTL_PRI, {1'h0, m[2], 6'h01});
            tx = 8'($urandom);
            mo = 8'($urandom);
            ub_byte(tx, mo);
        end
        // Data write in mid-byte is dropped
        wr(IDX_DATA, 8'h96);
        fork
            mst.xfer(8'h3c, 8, got);
            begin
                #2000;
                wr(IDX_DATA, 8'h5a);
            end
        join
        chk(got, 8'h96);
        repeat (8) @(posedge clk);
        rc(IDX_IRQ_FLG, 8'hc0, FM);
        irq_ack <= 1'h1;
        @(posedge clk);
        irq_ack <= 1'h0;
        rc(IDX_IRQ_FLG, 8'h00, FM);
        // Byte cut by deselect, then by deep sleep
        for (k = 0; k < 2; k++)
        begin
            fork
                mst.xfer(8'h3c, k ? 8 : 3, got);
                begin
                    #1500;
                    @(posedge clk);
                    sleep_deep <= k[0];
                end
            join
            @(posedge clk);
            sleep_deep <= 1'h0;
            repeat (8) @(posedge clk);
            chk({7'h0, miso_oe}, 8'h00);
            rc(IDX_IRQ_FLG, 8'h00, FM);
            ub_byte(8'ha5, 8'h1e);
        end
        // Buffered, no wait: dummy first, full buffer refuses
        wr(IDX_CTL_SEC, 8'h83);
        wr(IDX_DATA, 8'h43);
        bx(8'h11, 8'h1e);
        rc(IDX_IRQ_FLG, 8'hb0);
        wr(IDX_DATA, 8'h44);
        wr(IDX_DATA, 8'h45);
        rc(IDX_IRQ_FLG, 8'h80, FM);
        bx(8'h22, 8'h43);
        bx(8'h33, 8'h44);
        void'(rxq.pop_back());
        rc(IDX_IRQ_FLG, 8'he1, FM);
        rc(IDX_DATA, rxq.pop_front());
        rc(IDX_DATA, rxq.pop_front());
        rc(IDX_IRQ_FLG, 8'h61, FM);
        wr(IDX_IRQ_EN, 8'h40);
        repeat (2) @(posedge clk);
        chk({7'h0, irq}, 8'h01);
        wr(IDX_IRQ_FLG, 8'hff);
        repeat (2) @(posedge clk);
        rc(IDX_IRQ_FLG, 8'h00, FM);
        chk({7'h0, irq}, 8'h00);
        // Buffered with wait: first write loads the shifter directly
        wr(IDX_CTL_SEC, 8'hc3);
        wr(IDX_DATA, 8'h6d);
        bx(8'h55, 8'h6d);
        rc(IDX_DATA, rxq.pop_front());
        conclude();
    end
endmodule // spi_slave_buffered_port_test
`default_nettype wire
